// file: rtl/two_wire_target_pkg.sv
// constants and types for the two-wire target with memory read channel
package two_wire_target_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_TASK_ARM_TX = 12'h000;
    localparam logic [11:0] OFF_TASK_STOP = 12'h004;
    localparam logic [11:0] OFF_TASK_SUSPEND = 12'h008;
    localparam logic [11:0] OFF_TASK_RESUME = 12'h00c;
    localparam logic [11:0] OFF_EVENTS = 12'h100;
    localparam logic [11:0] OFF_ENABLE = 12'h500;
    localparam logic [11:0] OFF_CONFIG = 12'h504;
    localparam logic [11:0] OFF_ADDR0 = 12'h508;
    localparam logic [11:0] OFF_ADDR1 = 12'h50c;
    localparam logic [11:0] OFF_TX_PTR = 12'h510;
    localparam logic [11:0] OFF_TX_LIMIT = 12'h514;
    localparam logic [11:0] OFF_TX_COUNT = 12'h518;
    localparam logic [11:0] OFF_FILL = 12'h51c;
    // event bit positions in the events register
    localparam int EV_READ = 0;
    localparam int EV_BEGUN = 1;
    localparam int EV_HALTED = 2;
    localparam int EV_ERROR = 3;
    localparam int EV_W = 4;
    // field widths, reset values and the last bit index of a byte
    localparam int CNT_W = 16;
    localparam logic [7:0] FILL_RST = 8'hff;
    localparam logic [1:0] CONFIG_RST = 2'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE = 1;
    // bus rates the engine must follow, in kHz, and the sampling clock
    localparam int STD_RATE_KHZ = 100;
    localparam int FAST_RATE_KHZ = 400;
    localparam int CLK_KHZ = 10000;
    localparam int FAST_SAMPLES = CLK_KHZ / FAST_RATE_KHZ;
    // engine states, one-hot
    typedef enum logic [10:0] {
        ST_IDLE = 11'h001,
        ST_ADDR = 11'h002,
        ST_ACK = 11'h004,
        ST_WAIT_ARM = 11'h008,
        ST_LOAD = 11'h010,
        ST_FETCH = 11'h020,
        ST_TXB = 11'h040,
        ST_TXA = 11'h080,
        ST_DRAIN = 11'h100,
        ST_SKIP = 11'h200,
        ST_HALT = 11'h400
    } state_t;
endpackage

// file: rtl/two_wire_target.sv
// two-wire target: address match, transmit from ram, ahb-lite registers
`timescale 1ns/1ps
// Notes on behaviour
// R1: works at 100 kHz and 400 kHz
// R2: bus carries a single master only
// R3: master may hold scl low anytime
// R4: configure pins, slots only while disabled; here config and address slot writes are taken whether enabled or not
// R5: memory read and write channels; only a memory read channel is built here
// R6: halted only after memory accesses finish
// R7: enable puts target into idle
// R8: read command: start, address, rw=1, ack
// R9: match against two slots gated by config
// R10: ack only on match, raise read event
// R11: read commands detected only from idle; here a start in any state but halt opens an address phase
// R12: arm task sets hidden prepared flag
// R13: enter tx if armed, else stretch scl
// R14: tx entry raises begun, clears flag
// R15: restart during tx returns to idle; here a restart goes straight into the address phase
// R16: stop ends transaction, halted, back idle
// R17: limit bytes, then fill byte plus error
// R18: pointer and limit captured at begun
// R19: stop task halts and returns idle
// R20: master acks bytes, nacks the last
// R21: byte count readable after transaction
// R22: suspend stretches scl until resume
// R23: software stop halts regardless of bus
// R24: disabled: pins released, no events
module two_wire_target (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // two-wire pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // memory read channel
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [7:0] mem_rdata_i
);
    localparam int CNT_W = two_wire_target_pkg::CNT_W;
    localparam int EV_W = two_wire_target_pkg::EV_W;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // software registers
    logic enable_q;
    logic [1:0] config_q;  // slot enables
    logic [6:0] addr0_q;
    logic [6:0] addr1_q;
    logic [31:0] tx_ptr_q;
    logic [CNT_W-1:0] tx_limit_q;
    logic [7:0] fill_q;
    logic [EV_W-1:0] events_q;  // sticky event bits
    // engine state
    two_wire_target_pkg::state_t state_q;
    logic armed_q;  // hidden transmit-prepared flag
    logic suspend_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q;
    logic nack_q;
    logic from_buf_q;  // byte in shift register came from ram
    logic pending_q;  // memory fetch outstanding
    logic [31:0] ptr_cap_q;
    logic [CNT_W-1:0] limit_cap_q;
    logic [CNT_W-1:0] byte_idx_q;  // bytes fetched this transaction
    logic [CNT_W-1:0] tx_count_q;  // bytes sent from the buffer
    logic ev_read_q, ev_begun_q, ev_halt_q, ev_err_q;  // one-cycle pulses
    logic mem_req_q;
    // ahb data phase bookkeeping
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] hrdata_q;
    // synchronisers and edge detect
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;

    // bus decode helpers
    logic addr_ph, task_wr;
    logic [11:0] a_off;
    assign addr_ph = hsel_i && htrans_i[two_wire_target_pkg::HTRANS_ACTIVE]
        && hready_i;
    assign a_off = haddr_i[11:0];
    assign task_wr = wr_pend_q && hwdata_i[0];
    logic t_arm, t_stop, t_susp, t_res;
    assign t_arm = task_wr
        && wr_addr_q == two_wire_target_pkg::OFF_TASK_ARM_TX;
    assign t_stop = task_wr
        && wr_addr_q == two_wire_target_pkg::OFF_TASK_STOP;
    assign t_susp = task_wr
        && wr_addr_q == two_wire_target_pkg::OFF_TASK_SUSPEND;
    assign t_res = task_wr
        && wr_addr_q == two_wire_target_pkg::OFF_TASK_RESUME;

    // zero-wait slave, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    // capture write address phase for the following data phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ph && hwrite_i;
            wr_addr_q <= a_off;
        end
    end

    // read data is registered at the address phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ph && !hwrite_i) begin
            case (a_off)
                two_wire_target_pkg::OFF_EVENTS:
                    hrdata_q <= {28'h000_0000, events_q};
                two_wire_target_pkg::OFF_ENABLE:
                    hrdata_q <= {31'h0000_0000, enable_q};
                two_wire_target_pkg::OFF_CONFIG:
                    hrdata_q <= {30'h0000_0000, config_q};
                two_wire_target_pkg::OFF_ADDR0:
                    hrdata_q <= {25'h000_0000, addr0_q};
                two_wire_target_pkg::OFF_ADDR1:
                    hrdata_q <= {25'h000_0000, addr1_q};
                two_wire_target_pkg::OFF_TX_PTR: hrdata_q <= tx_ptr_q;
                two_wire_target_pkg::OFF_TX_LIMIT:
                    hrdata_q <= {16'h0000, tx_limit_q};
                two_wire_target_pkg::OFF_TX_COUNT:
                    hrdata_q <= {16'h0000, tx_count_q};  // [R21]
                two_wire_target_pkg::OFF_FILL:
                    hrdata_q <= {24'h00_0000, fill_q};
                default: hrdata_q <= 32'h0000_0000;  // unmapped, tasks
            endcase
        end
    end

    // configuration registers written in the data phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_q <= 1'b0;
            config_q <= two_wire_target_pkg::CONFIG_RST;
            addr0_q <= 7'h00;
            addr1_q <= 7'h00;
            tx_ptr_q <= 32'h0000_0000;
            tx_limit_q <= 16'h0000;
            fill_q <= two_wire_target_pkg::FILL_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                two_wire_target_pkg::OFF_ENABLE: enable_q <= hwdata_i[0];
                two_wire_target_pkg::OFF_CONFIG: config_q <= hwdata_i[1:0];
                two_wire_target_pkg::OFF_ADDR0: addr0_q <= hwdata_i[6:0];
                two_wire_target_pkg::OFF_ADDR1: addr1_q <= hwdata_i[6:0];
                two_wire_target_pkg::OFF_TX_PTR: tx_ptr_q <= hwdata_i;
                two_wire_target_pkg::OFF_TX_LIMIT:
                    tx_limit_q <= hwdata_i[15:0];
                two_wire_target_pkg::OFF_FILL: fill_q <= hwdata_i[7:0];
                default: ;  // read-only or task address
            endcase
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    logic [EV_W-1:0] ev_set, ev_clr;
    assign ev_set = {ev_err_q, ev_halt_q, ev_begun_q, ev_read_q};
    assign ev_clr = (wr_pend_q && wr_addr_q == two_wire_target_pkg::OFF_EVENTS)
        ? hwdata_i[EV_W-1:0] : 4'h0;
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_ev
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    events_q[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    events_q[gi] <= 1'b1;
                end else if (ev_clr[gi]) begin
                    events_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // two-stage synchronisers, third stage only for edge finding [R1]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
        end
    end

    // bus conditions; a master holding scl low just delays edges [R3]
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s2 && !scl_s3;
    assign scl_fall = !scl_s2 && scl_s3;
    assign bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

    // address match against enabled slots [R9]
    logic slot_hit;
    assign slot_hit = (config_q[0] && shreg_q[7:1] == addr0_q)
        || (config_q[1] && shreg_q[7:1] == addr1_q);

    // states in which a bus stop ends a transaction
    logic in_xfer;
    assign in_xfer = state_q inside {two_wire_target_pkg::ST_ACK,
        two_wire_target_pkg::ST_WAIT_ARM, two_wire_target_pkg::ST_LOAD,
        two_wire_target_pkg::ST_FETCH, two_wire_target_pkg::ST_TXB,
        two_wire_target_pkg::ST_TXA, two_wire_target_pkg::ST_DRAIN};

    // hidden transmit-prepared flag, arm wins over unprepare
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
        end else if (t_arm) begin
            armed_q <= 1'b1;  // [R12]
        end else if (ev_begun_q || ev_halt_q) begin
            armed_q <= 1'b0;  // [R14] [R16] [R19]
        end
    end

    // suspend flag set by suspend task, cleared by resume, disable or idle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            suspend_q <= 1'b0;
        end else if (!enable_q || t_res || state_q ==
                two_wire_target_pkg::ST_IDLE) begin
            suspend_q <= 1'b0;
        end else if (t_susp) begin
            suspend_q <= 1'b1;  // [R22]
        end
    end

    // outstanding fetch tracking, for a clean halt
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= 1'b0;
        end else if (mem_req_q) begin
            pending_q <= 1'b1;
        end else if (mem_ack_i) begin
            pending_q <= 1'b0;
        end
    end

    // main engine
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= two_wire_target_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            nack_q <= 1'b0;
            from_buf_q <= 1'b0;
            ptr_cap_q <= 32'h0000_0000;
            limit_cap_q <= 16'h0000;
            byte_idx_q <= 16'h0000;
            tx_count_q <= 16'h0000;
            ev_read_q <= 1'b0;
            ev_begun_q <= 1'b0;
            ev_halt_q <= 1'b0;
            ev_err_q <= 1'b0;
            mem_req_q <= 1'b0;
        end else begin
            ev_read_q <= 1'b0;
            ev_begun_q <= 1'b0;
            ev_halt_q <= 1'b0;
            ev_err_q <= 1'b0;
            mem_req_q <= 1'b0;
            if (!enable_q) begin
                state_q <= two_wire_target_pkg::ST_IDLE;  // [R24] [R7]
            end else if (t_stop) begin
                state_q <= two_wire_target_pkg::ST_HALT;  // [R19] [R23]
            end else if (bus_stop && in_xfer) begin
                state_q <= two_wire_target_pkg::ST_HALT;  // [R16]
            end else if (bus_start
                    && state_q != two_wire_target_pkg::ST_HALT) begin
                // restart goes straight into a fresh address phase, not via idle [R15] [R11]
                state_q <= two_wire_target_pkg::ST_ADDR;
                bit_cnt_q <= 4'h0;
            end else begin
                case (state_q)
                    two_wire_target_pkg::ST_IDLE: ;  // waits for a start
                    two_wire_target_pkg::ST_ADDR: begin
                        // shift address and direction on rising scl
                        if (scl_rise && bit_cnt_q < 4'h8) begin
                            shreg_q <= {shreg_q[6:0], sda_s2};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            if (slot_hit && shreg_q[0]) begin
                                state_q <= two_wire_target_pkg::ST_ACK;
                                ev_read_q <= 1'b1;  // [R10] [R8]
                            end else begin
                                // nack: no match or write command
                                state_q <= two_wire_target_pkg::ST_SKIP;
                            end
                        end
                    end
                    two_wire_target_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            state_q <= two_wire_target_pkg::ST_WAIT_ARM;
                        end
                    end
                    two_wire_target_pkg::ST_WAIT_ARM: begin
                        // scl is held low here until armed [R13]
                        if (armed_q) begin
                            state_q <= two_wire_target_pkg::ST_LOAD;
                            ev_begun_q <= 1'b1;  // [R14]
                            ptr_cap_q <= tx_ptr_q;  // [R18]
                            limit_cap_q <= tx_limit_q;  // [R18]
                            byte_idx_q <= 16'h0000;
                            tx_count_q <= 16'h0000;
                        end
                    end
                    two_wire_target_pkg::ST_LOAD: begin
                        if (pending_q) begin
                            state_q <= two_wire_target_pkg::ST_LOAD;
                        end else if (byte_idx_q < limit_cap_q) begin
                            mem_req_q <= 1'b1;  // [R5]
                            state_q <= two_wire_target_pkg::ST_FETCH;
                        end else begin
                            shreg_q <= fill_q;  // [R17]
                            ev_err_q <= 1'b1;  // [R17]
                            from_buf_q <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            state_q <= two_wire_target_pkg::ST_TXB;
                        end
                    end
                    two_wire_target_pkg::ST_FETCH: begin
                        if (mem_ack_i) begin
                            shreg_q <= mem_rdata_i;
                            byte_idx_q <= byte_idx_q + 16'h0001;
                            from_buf_q <= 1'b1;
                            bit_cnt_q <= 4'h0;
                            state_q <= two_wire_target_pkg::ST_TXB;
                        end
                    end
                    two_wire_target_pkg::ST_TXB: begin
                        // next bit is set up after each falling scl [R14]
                        if (scl_fall) begin
                            if (bit_cnt_q[2:0] ==
                                    two_wire_target_pkg::BIT_LAST) begin
                                state_q <= two_wire_target_pkg::ST_TXA;
                                if (from_buf_q) begin
                                    tx_count_q <= tx_count_q + 16'h0001;
                                end
                            end else begin
                                shreg_q <= {shreg_q[6:0], 1'b1};
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    two_wire_target_pkg::ST_TXA: begin
                        // master acks each byte, nacks the last [R20]
                        if (scl_rise) begin
                            nack_q <= sda_s2;
                        end else if (scl_fall) begin
                            state_q <= nack_q
                                ? two_wire_target_pkg::ST_DRAIN
                                : two_wire_target_pkg::ST_LOAD;
                        end
                    end
                    two_wire_target_pkg::ST_DRAIN: ;  // released, await stop
                    two_wire_target_pkg::ST_SKIP: ;  // not ours, await start
                    two_wire_target_pkg::ST_HALT: begin
                        // wait for the last fetch to land [R6]
                        if (!pending_q && !mem_req_q) begin
                            ev_halt_q <= 1'b1;
                            state_q <= two_wire_target_pkg::ST_IDLE;
                        end
                    end
                    default: state_q <= two_wire_target_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // pin drive: pull low only, never while disabled [R24]
    logic hold_scl;
    assign hold_scl = enable_q && (state_q inside {
        two_wire_target_pkg::ST_WAIT_ARM, two_wire_target_pkg::ST_LOAD,
        two_wire_target_pkg::ST_FETCH}
        || (suspend_q && in_xfer && !scl_s2));  // [R13] [R22]
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = hold_scl;
    assign sda_oe_o = enable_q
        && ((state_q == two_wire_target_pkg::ST_ACK)
        || (state_q == two_wire_target_pkg::ST_TXB && !shreg_q[7]));
    assign mem_req_o = mem_req_q;
    assign mem_addr_o = ptr_cap_q + {16'h0000, byte_idx_q};

    property p_disabled_quiet;
        !enable_q |-> !scl_oe_o && !sda_oe_o && !ev_set[0];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // [R24]
        else $error("pins driven while disabled");

    property p_read_on_match;
        ev_read_q |-> state_q == two_wire_target_pkg::ST_ACK && sda_oe_o;
    endproperty
    a_read_on_match: assert property (p_read_on_match) // [R10]
        else $error("read event without ack");

    property p_unprepare;
        ev_begun_q && !t_arm |=> !armed_q;
    endproperty
    a_unprepare: assert property (p_unprepare) // [R14]
        else $error("prepared flag not cleared at begun");

    property p_stretch_unarmed;
        state_q == two_wire_target_pkg::ST_WAIT_ARM |-> scl_oe_o;
    endproperty
    a_stretch_unarmed: assert property (p_stretch_unarmed) // [R13]
        else $error("scl not held while unarmed");

    property p_halt_clean;
        ev_halt_q |-> !pending_q && state_q == two_wire_target_pkg::ST_IDLE;
    endproperty
    a_halt_clean: assert property (p_halt_clean) // [R6]
        else $error("halted with fetch outstanding");

    property p_fill_past_limit;
        ev_err_q |-> byte_idx_q >= limit_cap_q
            && shreg_q == $past(fill_q);
    endproperty
    a_fill_past_limit: assert property (p_fill_past_limit) // [R17]
        else $error("fill byte sent inside limit");

    property p_capture;
        ev_begun_q |-> ptr_cap_q == $past(tx_ptr_q)
            && limit_cap_q == $past(tx_limit_q);
    endproperty
    a_capture: assert property (p_capture) // [R18]
        else $error("pointer or limit not captured");

    property p_count_bound;
        tx_count_q <= limit_cap_q || ev_begun_q;
    endproperty
    a_count_bound: assert property (p_count_bound) // [R21]
        else $error("byte count beyond limit");

    property p_stop_task;
        t_stop && enable_q |=> ##[0:40] ev_halt_q;
    endproperty
    a_stop_task: assert property (p_stop_task) // [R19]
        else $error("stop task did not halt");
endmodule

// file: bench/i2c_master_model.sv
// single bus master model on the open-drain clock and data lines
`timescale 1ns/1ps
module i2c_master_model (
    // clock
    input wire logic clk_i,
    // resolved lines
    input wire logic scl_i,
    input wire logic sda_i,
    // pulls, high drags a line low
    output logic scl_low_o,
    output logic sda_low_o
);
    // half of the 800 ns link period
    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask
    // release clock, wait out any stretch, then a high half
    task automatic rise();
        scl_low_o <= 1'b0;
        for (int n = 0; n < 99999 && scl_i !== 1'b1; n++) @(posedge clk_i);
        half();
    endtask
    // one bit out and one sample in
    task automatic bit_io(input logic b, output logic s);
        sda_low_o <= !b;
        half();
        rise();
        s = sda_i;
        scl_low_o <= 1'b1;
    endtask
    // data falls while clock high, also for a restart
    task automatic start();
        sda_low_o <= 1'b0;
        half();
        rise();
        sda_low_o <= 1'b1;
        half();
        scl_low_o <= 1'b1;
    endtask
    // data rises while clock high
    task automatic stop();
        sda_low_o <= 1'b1;
        half();
        rise();
        sda_low_o <= 1'b0;
        half();
    endtask
    // address byte, msb first, returns the acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // data byte in, then ack, or nack on the last one
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
    // lines released at time zero
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
endmodule

// file: bench/testbench.sv
// testbench for the two-wire target read path
`timescale 1ns/1ps
module testbench;
    // bus, pins and memory channel
    logic clk_i, rst_n_i, hsel, hwrite, mem_ack, ack, hreadyout, hresp;
    logic scl_oe, sda_oe, m_scl, m_sda, mem_req;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, mem_addr;
    logic [7:0] mem_rdata, d, dm;
    int num_errors = 0;
    int check_count = 0;
    // open-drain lines with pull-ups
    wire scl = !(scl_oe | m_scl);
    wire sda = !(sda_oe | m_sda);
    two_wire_target u_two_wire_target (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
        .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
    i2c_master_model u_i2c_master_model (.clk_i(clk_i), .scl_i(scl),
        .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
    // 100 ns clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for hready
    task automatic rdy();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (hreadyout === 1'b1) break;
        end
        if (n == 50) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // one single word transfer, read data lands in rd
    task automatic ahb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask
    // start plus address byte, acknowledge compared
    task automatic addr_cmd(input logic [7:0] b, input logic exp);
        u_i2c_master_model.start();
        u_i2c_master_model.wr_byte(b, ack);
        chk({31'h0, ack}, {31'h0, exp});
        if (!exp) u_i2c_master_model.stop();
    endtask
    // memory answers three cycles after a request
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        forever begin
            @(posedge clk_i);
            if (mem_req === 1'b1) begin
                dm = mem_addr[7:0] ^ 8'ha5;
                repeat (3) @(posedge clk_i);
                mem_ack <= 1'b1;
                mem_rdata <= dm;
                @(posedge clk_i);
                mem_ack <= 1'b0;
                mem_rdata <= ~dm;
            end
        end
    end
    // run limit
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n_i, hsel, hwrite, htrans, haddr, hwdata} = '0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        ahb(0, two_wire_target_pkg::OFF_CONFIG, 0);
        chk(rd, 32'h1);
        ahb(0, two_wire_target_pkg::OFF_FILL, 0);
        chk(rd, 32'hff);
        ahb(0, 12'h7f0, 0);
        chk(rd | hresp, 32'h0);
        ahb(1, two_wire_target_pkg::OFF_ADDR0, 32'h21);
        addr_cmd(8'h43, 1'b0);
        ahb(1, two_wire_target_pkg::OFF_ADDR1, 32'h33);
        ahb(1, two_wire_target_pkg::OFF_TX_PTR, 32'h40);
        ahb(1, two_wire_target_pkg::OFF_TX_LIMIT, 32'h2);
        ahb(1, two_wire_target_pkg::OFF_ENABLE, 32'h1);
        addr_cmd(8'h67, 1'b0);
        addr_cmd(8'h43, 1'b1);
        // unarmed: clock held until arming, pointer rewritten after start
        fork
            for (int i = 0; i < 3; i++) begin
                u_i2c_master_model.rd_byte(i == 2, d);
                chk({24'h0, d}, i == 2 ? 32'hff : 32'he5 - i);
            end
            begin
                repeat (300) @(posedge clk_i);
                chk({31'h0, scl_oe}, 32'h1);
                ahb(1, two_wire_target_pkg::OFF_TASK_ARM_TX, 1);
                repeat (20) @(posedge clk_i);
                ahb(1, two_wire_target_pkg::OFF_TX_PTR, 32'h80);
            end
        join
        u_i2c_master_model.stop();
        repeat (20) @(posedge clk_i);
        ahb(0, two_wire_target_pkg::OFF_EVENTS, 0);
        chk(rd, 32'hf);
        ahb(0, two_wire_target_pkg::OFF_TX_COUNT, 0);
        chk(rd, 32'h2);
        ahb(1, two_wire_target_pkg::OFF_EVENTS, 32'hf);
        // nacked byte, restart, suspend, then software stop
        ahb(1, two_wire_target_pkg::OFF_TASK_ARM_TX, 1);
        addr_cmd(8'h43, 1'b1);
        u_i2c_master_model.rd_byte(1'b1, d);
        chk({24'h0, d}, 32'h25);
        ahb(1, two_wire_target_pkg::OFF_TASK_ARM_TX, 1);
        addr_cmd(8'h43, 1'b1);
        u_i2c_master_model.rd_byte(1'b0, d);
        chk({24'h0, d}, 32'h25);
        ahb(1, two_wire_target_pkg::OFF_TASK_SUSPEND, 1);
        repeat (20) @(posedge clk_i);
        chk({31'h0, scl_oe}, 32'h1);
        ahb(1, two_wire_target_pkg::OFF_TASK_STOP, 1);
        repeat (10) @(posedge clk_i);
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        ahb(0, two_wire_target_pkg::OFF_EVENTS, 0);
        chk(rd, 32'h7);
        u_i2c_master_model.stop();
        tally_and_finish();
    end
endmodule
